// [hw/afq_pkg.sv]
/*
 * afq_pkg: constants shared by the stream queue and its storage module.
 * assumes: included first in compile order; one 20 MHz clock.
 */
package afq_pkg;
    localparam int DATA_W = 8;
    localparam int USER_W = 4;
    localparam int INFO_W = DATA_W + USER_W + 1;
    localparam int DEPTH = 8;
    localparam int MAX_DEPTH = 131072;
    localparam int MAX_STREAM_W = 4096;
    localparam int ADDR_W = $clog2(DEPTH);
    localparam int CNT_W = ADDR_W + 1;
    localparam int SYNC_STAGES = 3;
    localparam logic [CNT_W-1:0] FULL_THRESH = 4'h6;
    localparam logic [CNT_W-1:0] EMPTY_THRESH = 4'h2;
    localparam logic [1:0] STRUCT_QUEUE = 2'h0;
    localparam logic [1:0] STRUCT_SLICE = 2'h1;
    localparam logic [1:0] STRUCT_WIRE = 2'h2;
    localparam logic [1:0] STRUCT_SEL = STRUCT_QUEUE;
    typedef enum logic [2:0] {
        ST_RESET = 3'h1,
        ST_EMPTY = 3'h2,
        ST_BUSY = 3'h4
    } afq_state_t;
endpackage : afq_pkg

// [hw/afq_store_if.sv]
/*
 * afq_store_if: write and read ports of the storage ram.
 * assumes: driven by the queue control and one clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface afq_store_if;
    logic wr_en;
    logic [afq_pkg::ADDR_W-1:0] wr_addr;
    logic [afq_pkg::INFO_W-1:0] wr_data;
    logic [afq_pkg::ADDR_W-1:0] rd_addr;
    logic [afq_pkg::INFO_W-1:0] rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : afq_store_if
`default_nettype wire

// [hw/afq_ram.sv]
/*
 * afq_ram: simple dual port ram, registered read data.
 * assumes: read address valid one cycle before data is used.
 */
`timescale 1ns/100ps
`default_nettype none
module afq_ram #(
    parameter int WIDTH = afq_pkg::INFO_W,
    parameter int DEPTH = afq_pkg::DEPTH
) (
    input wire logic clock,
    afq_store_if.mem st
);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] rd_r;

    // ram cells carry no reset so they map onto block or distributed ram
    always_ff @(posedge clock) begin
        if (st.wr_en) begin
            mem_r[st.wr_addr] <= st.wr_data;
        end
        rd_r <= mem_r[st.rd_addr];
    end
    assign st.rd_data = rd_r;
endmodule : afq_ram
`default_nettype wire

// [hw/afq_stream_fifo.sv]
/*
 * afq_stream_fifo: 8 word stream queue with preview output.
 * assumes: one clock, source and sink logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module afq_stream_fifo (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [afq_pkg::DATA_W-1:0] s_data,
    input wire logic [afq_pkg::USER_W-1:0] s_user,
    input wire logic s_last,
    output logic m_valid,
    input wire logic m_ready,
    output logic [afq_pkg::DATA_W-1:0] m_data,
    output logic [afq_pkg::USER_W-1:0] m_user,
    output logic m_last,
    output logic threshold_nearly_full,
    output logic threshold_nearly_empty
);
    localparam int AW = afq_pkg::ADDR_W;
    localparam int CW = afq_pkg::CNT_W;
    localparam logic [CW-1:0] DEPTH_C = CW'(afq_pkg::DEPTH);

    // single clock: no pointer crossing is needed
    initial begin
        if (afq_pkg::DEPTH > afq_pkg::MAX_DEPTH || afq_pkg::DEPTH < 2)
            $error("queue depth out of range");
        if (afq_pkg::DATA_W < 1 || afq_pkg::DATA_W > afq_pkg::MAX_STREAM_W)
            $error("stream width out of range");
    end

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(afq_pkg::DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction : ptr_inc

    afq_store_if st ();
    afq_ram #(.WIDTH(afq_pkg::INFO_W), .DEPTH(afq_pkg::DEPTH)) i_afq_ram (
        .clock(clock),
        .st(st)
    );

    logic [afq_pkg::INFO_W-1:0] in_word;
    logic [afq_pkg::INFO_W-1:0] out_word;
    assign in_word = {s_last, s_user, s_data};

    afq_pkg::afq_state_t state_r, state_nxt;
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [afq_pkg::INFO_W-1:0] out_r, out_nxt;
    logic oval_r, oval_nxt;
    logic ordy_r, ordy_nxt;
    logic nf_r, nf_nxt, ne_r, ne_nxt;
    logic wr_fire, rd_fire, load_out;
    logic [CW-1:0] ram_cnt;
    logic wr_last_r, wr_last_nxt;
    logic [CW-1:0] ram_avail;

    // cnt_r counts words in ram and output stage together
    assign ram_cnt = cnt_r - CW'(oval_r);
    // a word written at the last edge is not yet in the registered read data
    assign ram_avail = ram_cnt - CW'(wr_last_r);

    always_comb begin
        state_nxt = state_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        out_nxt = out_r;
        oval_nxt = oval_r;
        wr_fire = 1'b0;
        rd_fire = 1'b0;
        load_out = 1'b0;
        unique case (afq_pkg::STRUCT_SEL)
            afq_pkg::STRUCT_SLICE: begin
                wr_fire = s_valid && s_ready;
                rd_fire = m_valid && m_ready;
                if (wr_fire) begin
                    out_nxt = in_word;
                    oval_nxt = 1'b1;
                end else if (rd_fire) begin
                    oval_nxt = 1'b0;
                end
                cnt_nxt = CW'(oval_nxt);
            end
            default: begin
                wr_fire = s_valid && s_ready;
                rd_fire = m_valid && m_ready;
                if (wr_fire) begin
                    wp_nxt = ptr_inc(wp_r);
                end
                // ram read data lags its address by one clock, so a word is
                // pulled into the output stage only once the read has seen it
                load_out = (ram_avail != '0) && (!oval_r || rd_fire);
                if (load_out) begin
                    rp_nxt = ptr_inc(rp_r);
                    out_nxt = st.rd_data;
                    oval_nxt = 1'b1;
                end else if (rd_fire) begin
                    oval_nxt = 1'b0;
                end
                cnt_nxt = cnt_r + CW'(wr_fire) - CW'(rd_fire);
            end
        endcase
        unique case (state_r)
            afq_pkg::ST_RESET: state_nxt = afq_pkg::ST_EMPTY;
            afq_pkg::ST_EMPTY: state_nxt = (cnt_nxt != '0) ? afq_pkg::ST_BUSY : afq_pkg::ST_EMPTY;
            afq_pkg::ST_BUSY: state_nxt = (cnt_nxt == '0) ? afq_pkg::ST_EMPTY : afq_pkg::ST_BUSY;
            default: state_nxt = afq_pkg::ST_RESET;
        endcase
    end

    // flag group: ready, thresholds and the marker of the last ram write
    always_comb begin
        wr_last_nxt = st.wr_en;
        // ready rises on leaving reset; later it drops only when no free entry is left
        if (state_r == afq_pkg::ST_RESET)
            ordy_nxt = 1'b1;
        else if (afq_pkg::STRUCT_SEL == afq_pkg::STRUCT_SLICE)
            ordy_nxt = !oval_nxt;
        else
            ordy_nxt = (cnt_nxt < DEPTH_C);
        nf_nxt = (cnt_nxt >= afq_pkg::FULL_THRESH);
        ne_nxt = (cnt_nxt <= afq_pkg::EMPTY_THRESH);
    end

    // ram read address looks ahead so the next word is waiting
    assign st.wr_en = wr_fire && (afq_pkg::STRUCT_SEL == afq_pkg::STRUCT_QUEUE);
    assign st.wr_addr = wp_r;
    assign st.wr_data = in_word;
    assign st.rd_addr = rp_nxt;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= afq_pkg::ST_RESET;
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            out_r <= '0;
            oval_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            out_r <= out_nxt;
            oval_r <= oval_nxt;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ordy_r <= 1'b0;
            nf_r <= 1'b0;
            ne_r <= 1'b1;
            wr_last_r <= 1'b0;
        end else begin
            ordy_r <= ordy_nxt;
            nf_r <= nf_nxt;
            ne_r <= ne_nxt;
            wr_last_r <= wr_last_nxt;
        end
    end

    // pass-through wire bypasses all storage
    always_comb begin
        if (afq_pkg::STRUCT_SEL == afq_pkg::STRUCT_WIRE) begin
            s_ready = m_ready && rst_b;
            m_valid = s_valid && rst_b;
            out_word = in_word;
        end else begin
            s_ready = ordy_r;
            m_valid = oval_r;
            out_word = out_r;
        end
    end
    assign {m_last, m_user, m_data} = out_word;
    assign threshold_nearly_full = nf_r;
    assign threshold_nearly_empty = ne_r;

    a_ready_full: assert property (@(posedge clock) disable iff (!rst_b)
        (afq_pkg::STRUCT_SEL == afq_pkg::STRUCT_QUEUE && state_r != afq_pkg::ST_RESET)
        |-> (s_ready == (cnt_r < DEPTH_C)))
        else $error("ready does not track free space");
    a_valid_data: assert property (@(posedge clock) disable iff (!rst_b)
        (cnt_r != '0) |-> ##[0:2] (m_valid || cnt_r == '0))
        else $error("valid not raised with stored word");
    a_valid_empty: assert property (@(posedge clock) disable iff (!rst_b)
        (cnt_r == '0) |-> !m_valid)
        else $error("valid high with empty queue");
    a_count_step: assert property (@(posedge clock) disable iff (!rst_b)
        ##1 (cnt_r == $past(cnt_r) + CW'($past(s_valid && s_ready))
             - CW'($past(m_valid && m_ready))))
        else $error("count not moved by handshakes");
    a_hold_stall: assert property (@(posedge clock) disable iff (!rst_b)
        (m_valid && !m_ready) |=> (m_valid && $stable(out_word)))
        else $error("output changed while stalled");
    a_count_bound: assert property (@(posedge clock) disable iff (!rst_b)
        cnt_r <= DEPTH_C)
        else $error("count above depth");
    a_near_full: assert property (@(posedge clock) disable iff (!rst_b)
        threshold_nearly_full == (cnt_r >= afq_pkg::FULL_THRESH))
        else $error("nearly full flag wrong");
    a_reset_ready: assert property (@(posedge clock)
        !rst_b |-> (!s_ready && !m_valid))
        else $error("handshake active in reset");
    a_first_word: assert property (@(posedge clock) disable iff (!rst_b)
        (cnt_r == '0 && s_valid && s_ready) |-> ##[1:3] m_valid)
        else $error("first word did not fall through");
    a_near_empty: assert property (@(posedge clock) disable iff (!rst_b)
        threshold_nearly_empty == (cnt_r <= afq_pkg::EMPTY_THRESH))
        else $error("nearly empty flag wrong");
    a_full_no_ready: assert property (@(posedge clock) disable iff (!rst_b)
        (cnt_r == DEPTH_C) |-> !s_ready)
        else $error("ready high with queue full");
    a_space_ready: assert property (@(posedge clock) disable iff (!rst_b)
        (state_r != afq_pkg::ST_RESET && cnt_r < DEPTH_C) |-> s_ready)
        else $error("ready low with space left");
    a_refused_hold: assert property (@(posedge clock) disable iff (!rst_b)
        (s_valid && !s_ready && !(m_valid && m_ready)) |=> (cnt_r == $past(cnt_r)))
        else $error("refused word was counted");
    a_write_count: assert property (@(posedge clock) disable iff (!rst_b)
        (s_valid && s_ready && !(m_valid && m_ready)) |=> (cnt_r == $past(cnt_r) + CW'(1)))
        else $error("write did not add one word");
    a_read_count: assert property (@(posedge clock) disable iff (!rst_b)
        (m_valid && m_ready && !(s_valid && s_ready)) |=> (cnt_r == $past(cnt_r) - CW'(1)))
        else $error("read did not remove one word");
    a_stall_count: assert property (@(posedge clock) disable iff (!rst_b)
        (m_valid && !m_ready && !s_valid) |=> (cnt_r == $past(cnt_r)))
        else $error("count moved with no handshake");
    a_state_onehot: assert property (@(posedge clock) disable iff (!rst_b)
        $onehot(state_r))
        else $error("state code not one-hot");
    a_state_busy: assert property (@(posedge clock) disable iff (!rst_b)
        (state_r == afq_pkg::ST_BUSY) == (cnt_r != '0))
        else $error("busy state disagrees with count");
    a_reset_count: assert property (@(posedge clock) disable iff (!rst_b)
        (state_r == afq_pkg::ST_RESET) |-> (cnt_r == '0 && wp_r == '0 && rp_r == '0))
        else $error("queue not emptied by reset");
    a_reset_leave: assert property (@(posedge clock) disable iff (!rst_b)
        (state_r == afq_pkg::ST_RESET) |=> (state_r == afq_pkg::ST_EMPTY && s_ready))
        else $error("ready not raised after reset");
    a_reset_out: assert property (@(posedge clock)
        !rst_b |-> (out_word == '0 && !threshold_nearly_full && threshold_nearly_empty))
        else $error("outputs not cleared in reset");
    a_fall_through: assert property (@(posedge clock) disable iff (!rst_b)
        (!m_valid && ram_cnt >= CW'(2)) |=> m_valid)
        else $error("stored word did not fall through");
    a_busy_valid: assert property (@(posedge clock) disable iff (!rst_b)
        (cnt_r != '0 && !m_valid) |-> ##[1:2] m_valid)
        else $error("valid late for stored word");
    a_back_to_back: assert property (@(posedge clock) disable iff (!rst_b)
        (m_valid && m_ready && ram_cnt >= CW'(2)) |=> m_valid)
        else $error("bubble with words waiting");
    a_load_bubble: assert property (@(posedge clock) disable iff (!rst_b)
        (m_valid && m_ready && ram_cnt == '0) |=> !m_valid)
        else $error("valid stayed high after last word");
    a_valid_fall: assert property (@(posedge clock) disable iff (!rst_b)
        (m_valid && m_ready && cnt_r == CW'(1)) |=> !m_valid)
        else $error("valid high after queue emptied");
    a_ready_rise: assert property (@(posedge clock) disable iff (!rst_b)
        (!s_ready && m_valid && m_ready && state_r != afq_pkg::ST_RESET) |=> s_ready)
        else $error("ready not raised after read");
    a_ready_fall: assert property (@(posedge clock) disable iff (!rst_b)
        (s_valid && s_ready && cnt_r == DEPTH_C - CW'(1) && !(m_valid && m_ready))
        |=> !s_ready)
        else $error("ready high after last entry filled");
    a_ready_flag: assert property (@(posedge clock) disable iff (!rst_b)
        (!s_ready && state_r != afq_pkg::ST_RESET) |-> threshold_nearly_full)
        else $error("full without nearly full flag");
    a_empty_flags: assert property (@(posedge clock) disable iff (!rst_b)
        (cnt_r == '0) |-> (threshold_nearly_empty && !threshold_nearly_full))
        else $error("flags wrong when empty");
    a_full_flags: assert property (@(posedge clock) disable iff (!rst_b)
        (cnt_r == DEPTH_C) |-> (threshold_nearly_full && !threshold_nearly_empty))
        else $error("flags wrong when full");
    a_wr_ram: assert property (@(posedge clock) disable iff (!rst_b)
        st.wr_en == (s_valid && s_ready))
        else $error("ram write not tied to handshake");
    a_rp_gap: assert property (@(posedge clock) disable iff (!rst_b)
        AW'(wp_r - rp_r) == AW'(ram_cnt))
        else $error("pointers disagree with count");

    c_fill: cover property (@(posedge clock) disable iff (!rst_b) cnt_r == DEPTH_C);
    c_both: cover property (@(posedge clock) disable iff (!rst_b)
        s_valid && s_ready && m_valid && m_ready);
    c_stall: cover property (@(posedge clock) disable iff (!rst_b) (m_valid && !m_ready) [*3]);
    c_refused: cover property (@(posedge clock) disable iff (!rst_b) s_valid && !s_ready);
    c_drain: cover property (@(posedge clock) disable iff (!rst_b)
        cnt_r == 4'h1 ##1 cnt_r == '0);
endmodule : afq_stream_fifo
`default_nettype wire

// [verification/afq_sink_model.sv]
/*
 * afq_sink_model: downstream sink that stalls on request and reports each word taken.
 * assumes: same clock as the queue; stall is driven just after a rising edge.
 */
`timescale 1ns/100ps
`default_nettype none
module afq_sink_model (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic stall,
    input wire logic m_valid,
    output logic m_ready,
    input wire logic [afq_pkg::DATA_W-1:0] m_data,
    input wire logic [afq_pkg::USER_W-1:0] m_user,
    input wire logic m_last,
    output logic taken,
    output logic [afq_pkg::INFO_W-1:0] taken_word
);
    // ready is registered, so it only moves just after an edge
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            m_ready <= 1'b0;
            taken <= 1'b0;
            taken_word <= '0;
        end else begin
            m_ready <= !stall;
            taken <= m_valid && m_ready;
            taken_word <= {m_last, m_user, m_data};
        end
    end
endmodule : afq_sink_model
`default_nettype wire

// [verification/axi_first_word_preview_mode_fifo_bench.sv]
/*
 * axi_first_word_preview_mode_fifo_bench: self-checking bench for the stream queue.
 * assumes: afq_pkg compiled first; sink model on the output side.
 */
`timescale 1ns/100ps
`default_nettype none
module axi_first_word_preview_mode_fifo_bench;
    logic clock = 1'b0, rst_b = 1'b1, s_valid = 1'b0, s_last = 1'b0, stall = 1'b1;
    logic [afq_pkg::DATA_W-1:0] s_data = '0;
    logic [afq_pkg::USER_W-1:0] s_user = '0;
    logic s_ready, m_valid, m_ready, m_last, nfull, nempty, taken;
    logic [afq_pkg::DATA_W-1:0] m_data;
    logic [afq_pkg::USER_W-1:0] m_user;
    logic [afq_pkg::INFO_W-1:0] taken_word;
    int fails = 0, num_checks = 0;

    always #25 clock = ~clock;

    afq_stream_fifo i_afq_stream_fifo (.clock(clock), .rst_b(rst_b), .s_valid(s_valid),
        .s_ready(s_ready), .s_data(s_data), .s_user(s_user), .s_last(s_last),
        .m_valid(m_valid), .m_ready(m_ready), .m_data(m_data), .m_user(m_user),
        .m_last(m_last), .threshold_nearly_full(nfull), .threshold_nearly_empty(nempty));
    afq_sink_model i_afq_sink_model (.clock(clock), .rst_b(rst_b), .stall(stall),
        .m_valid(m_valid), .m_ready(m_ready), .m_data(m_data), .m_user(m_user),
        .m_last(m_last), .taken(taken), .taken_word(taken_word));

    function automatic logic [afq_pkg::INFO_W-1:0] word_of(input int i);
        return {i == 7, 4'(i), 8'(8'hC3 ^ (i * 8'h11))};
    endfunction : word_of

    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task push(input int i);
        int n;
        n = 0;
        s_valid <= 1'b1;
        {s_last, s_user, s_data} <= word_of(i);
        do begin
            @(posedge clock);
            n++;
        end while (!s_ready && n < 50);
        chk("push accepted", 16'h0001, 16'(s_ready));
    endtask : push

    task idle(input int k);
        s_valid <= 1'b0;
        repeat (k) @(posedge clock);
    endtask : idle

    // the sink stalls one cycle in four so the head word must hold
    task drain(input int first, input int cnt);
        int got_n, n;
        got_n = 0;
        n = 0;
        while (got_n < cnt && n < 200) begin
            @(posedge clock);
            n++;
            stall <= n[1] & n[0];
            if (taken) begin
                chk("drained word", 16'(word_of(first + got_n)), 16'(taken_word));
                got_n++;
            end
        end
        chk("drain count", 16'(cnt), 16'(got_n));
        stall <= 1'b1;
    endtask : drain

    task test_reset;
        // a real falling edge, so the queue is cleared before the first clock
        rst_b <= 1'b0;
        repeat (4) @(posedge clock);
        chk("ready in reset", 16'h0000, 16'(s_ready));
        chk("valid in reset", 16'h0000, 16'(m_valid));
        chk("nearly empty in reset", 16'h0001, 16'(nempty));
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);
        chk("ready after reset", 16'h0001, 16'(s_ready));
        $display("test reset done");
    endtask : test_reset

    task test_fill_drain;
        for (int i = 0; i < 8; i++) push(i);
        idle(2);
        chk("ready when full", 16'h0000, 16'(s_ready));
        chk("valid when full", 16'h0001, 16'(m_valid));
        chk("nearly full", 16'h0001, 16'(nfull));
        chk("nearly empty full", 16'h0000, 16'(nempty));
        chk("head word", 16'(word_of(0)), 16'({m_last, m_user, m_data}));
        s_valid <= 1'b1;
        s_data <= 8'hEE;
        repeat (3) @(posedge clock);
        chk("ready stays low", 16'h0000, 16'(s_ready));
        idle(1);
        drain(0, 8);
        idle(3);
        chk("valid when empty", 16'h0000, 16'(m_valid));
        chk("nearly empty", 16'h0001, 16'(nempty));
        chk("ready when empty", 16'h0001, 16'(s_ready));
        $display("test fill and drain done");
    endtask : test_fill_drain

    task test_mid_reset;
        for (int i = 0; i < 3; i++) push(i);
        idle(1);
        rst_b <= 1'b0;
        @(posedge clock);
        chk("ready mid reset", 16'h0000, 16'(s_ready));
        chk("valid mid reset", 16'h0000, 16'(m_valid));
        chk("nearly empty mid reset", 16'h0001, 16'(nempty));
        rst_b <= 1'b1;
        idle(3);
        chk("queue emptied", 16'h0000, 16'(m_valid));
        push(5);
        idle(3);
        drain(5, 1);
        $display("test mid reset done");
    endtask : test_mid_reset

    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    initial begin
        test_reset();
        test_fill_drain();
        test_mid_reset();
        wrap_up();
    end

    initial begin
        #(50 * 2000);
        fails++;
        wrap_up();
    end
endmodule : axi_first_word_preview_mode_fifo_bench
`default_nettype wire
